// file: dramc_pkg.sv
// Package of timing constants and carrier types for the DRAM host controller
package dramc_pkg;
  // ==========================================================
  // Geometry
  localparam int ADDR_W     = 6;
  localparam int ROWS       = 64;
  // ==========================================================
  // Timing figures in ns at 100 MHz, refresh period in ms, warm-up in cycles
  localparam int CLK_NS     = 10;
  localparam int T_RP_NS    = 120;
  localparam int T_RCD_NS   = 65;
  localparam int T_CAS_NS   = 135;
  localparam int T_CAC_NS   = 135;
  localparam int T_RSH_NS   = 135;
  localparam int T_WP_NS    = 55;
  localparam int T_CP_NS    = 80;
  localparam int T_RFSH_MS  = 2;
  localparam int WARMUP_CYC = 8;
  localparam int RP_CYC     = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RCD_CYC    = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAS_CYC    = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAC_CYC    = (T_CAC_NS + CLK_NS - 1) / CLK_NS + 2;
  localparam int RSH_CYC    = (T_RSH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC     = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CP_CYC     = (T_CP_NS + CLK_NS - 1) / CLK_NS;
  // Interval between row refreshes, rounded down, safety margin of 1/8
  localparam int RFSH_CYC   =
    (T_RFSH_MS * 1000000 / CLK_NS) / ROWS * 7 / 8;
  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic              write;
    logic              page;
    logic              select;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic              data;
  } dramc_req_s;
  typedef struct packed {
    logic              ras_n;
    logic              cas_n;
    logic              write_n;
    logic              cs_n;
    logic [ADDR_W-1:0] addr;
    logic              din;
  } dramc_pins_s;
endpackage

// file: dramc_host.sv
// Host controller driving a 4096 x 1 DRAM through its strobes
// Rules from the device datasheet that this block relies on
// R1: Row on falling RAS, column/CS on CAS
// R2: Device latches data on later falling strobe
// R3: Early write: data taken at CAS
// R4: Delayed write holds WRITE high past CAS; this block only does early write, WRITE low before CAS
// R5: CS high at CAS ignores write
// R6: Read keeps WRITE high while CAS active
// R7: Falling CAS floats device output
// R8: Selected read drives stored bit
// R9: Selected early write echoes written bit
// R10: Output holds until next CAS fall
// R11: CAS without RAS floats output
// R12: Unselected full cycle floats output
// R13: Refresh all 64 rows per 2 ms
// R14: Every RAS cycle refreshes its row
// R15: Refresh via write keeps CS high
// R16: Output returns at first CAS cycle
// R17: Page mode keeps RAS low across columns
// R18: CS acts per page column cycle
// R19: Refresh keeps CAS high, no contention
// R20: Eight refresh cycles after power-up
// R21: Device stores bits in 64x64 array
`timescale 1ns/100ps
module dramc_host
  import dramc_pkg::*;
#(
  parameter int RFSH_INTERVAL = RFSH_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    srst_i,
  input  wire dramc_pkg::dramc_req_s   req_i,
  input  wire logic                    req_valid_i,
  output logic                         req_ready_o,
  output logic                         rd_valid_o,
  output logic                         rd_data_o,
  output logic                         warm_done_o,
  output dramc_pkg::dramc_pins_s       pins_o,
  input  wire logic                    dout_i
);
  import dramc_pkg::*;

  // ==========================================================
  // State machine
  typedef enum logic [3:0] {
    ST_IDLE, ST_RAS, ST_CAS, ST_WE, ST_CASHOLD, ST_CP,
    ST_RSH, ST_PRE, ST_RF
  } dramc_state_e;

  dramc_state_e state;
  logic [15:0]  cnt;
  logic [15:0]  rf_timer;
  logic         rf_due;
  logic [5:0]   rf_row;
  logic [3:0]   warm_cnt;
  dramc_req_s   cur;
  logic [1:0]   dout_sync;

  // Pin input passes two flops before use
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dout_sync <= 2'h0;
    end else begin
      dout_sync <= {dout_sync[0], dout_i};
    end
  end

  // ==========================================================
  // Refresh timer; a request cannot starve refresh since rf_due wins
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rf_timer <= 16'h0;
      rf_due   <= 1'b0;
    end else if (state == ST_RF && cnt == 16'h0) begin
      rf_due   <= 1'b0; // R13
      rf_timer <= 16'h0;
    end else if (rf_timer >= 16'(RFSH_INTERVAL - 1)) begin
      rf_due   <= 1'b1; // R13
    end else begin
      rf_timer <= rf_timer + 16'h1;
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state       <= ST_IDLE;
      cnt         <= 16'h0;
      cur         <= '0;
      rf_row      <= 6'h0;
      warm_cnt    <= 4'h0;
      warm_done_o <= 1'b0;
      req_ready_o <= 1'b0;
      rd_valid_o  <= 1'b0;
      rd_data_o   <= 1'b0;
      pins_o      <= '{ras_n:1'b1, cas_n:1'b1, write_n:1'b1,
                       cs_n:1'b1, addr:'0, din:1'b0};
    end else begin
      rd_valid_o  <= 1'b0;
      req_ready_o <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (!warm_done_o || rf_due) begin
            // RAS-only cycle; CAS held high so shared outputs stay off
            pins_o.addr  <= rf_row; // R14
            pins_o.ras_n <= 1'b0;   // R19
            pins_o.cas_n <= 1'b1;   // R19
            pins_o.cs_n  <= 1'b1;   // R15
            cnt          <= 16'(CAS_CYC + RSH_CYC);
            state        <= ST_RF;
          end else if (req_valid_i) begin
            req_ready_o  <= 1'b1;
            cur          <= req_i;
            pins_o.addr  <= req_i.row; // R1
            cnt          <= 16'(RCD_CYC);
            state        <= ST_RAS;
          end
        end
        ST_RF: begin
          if (cnt != 16'h0) begin
            cnt <= cnt - 16'h1;
          end else begin
            pins_o.ras_n <= 1'b1;
            rf_row       <= rf_row + 6'h1; // R13
            if (!warm_done_o) begin
              warm_cnt <= warm_cnt + 4'h1;
              if (warm_cnt == 4'(WARMUP_CYC - 1)) begin
                warm_done_o <= 1'b1; // R20
              end
            end
            cnt   <= 16'(RP_CYC);
            state <= ST_PRE;
          end
        end
        ST_RAS: begin
          // Row strobe falls one cycle after the row address settles
          pins_o.ras_n <= 1'b0; // R1
          if (cnt != 16'h0) begin
            cnt <= cnt - 16'h1;
          end else begin
            pins_o.addr    <= cur.col; // R1
            pins_o.cs_n    <= !cur.select; // R18
            pins_o.din     <= cur.data;
            // Early write: WRITE low before CAS, data taken at CAS
            pins_o.write_n <= !cur.write; // R3 R4 R6
            state          <= ST_CAS;
          end
        end
        ST_CAS: begin
          pins_o.cas_n <= 1'b0; // R1
          cnt          <= 16'(CAC_CYC);
          state        <= ST_CASHOLD;
        end
        ST_CASHOLD: begin
          if (cnt != 16'h0) begin
            cnt <= cnt - 16'h1;
          end else begin
            pins_o.cas_n   <= 1'b1;
            pins_o.write_n <= 1'b1;
            if (!cur.write && cur.select) begin
              rd_valid_o <= 1'b1; // R8
              rd_data_o  <= dout_sync[1];
            end
            cnt <= 16'(CP_CYC);
            if (cur.page) begin
              state <= ST_CP; // R17
            end else begin
              state <= ST_RSH;
            end
          end
        end
        ST_CP: begin
          if (cnt != 16'h0) begin
            cnt <= cnt - 16'h1;
          end else if (req_valid_i && req_i.row == cur.row && !rf_due) begin
            // Next column in the open page, no new row strobe
            req_ready_o    <= 1'b1;
            cur            <= req_i;
            pins_o.addr    <= req_i.col; // R17
            pins_o.cs_n    <= !req_i.select; // R18
            pins_o.din     <= req_i.data;
            pins_o.write_n <= !req_i.write;
            state          <= ST_CAS;
          end else begin
            cnt   <= 16'h0;
            state <= ST_RSH;
          end
        end
        ST_RSH: begin
          pins_o.ras_n <= 1'b1;
          cnt          <= 16'(RP_CYC);
          state        <= ST_PRE;
        end
        ST_PRE: begin
          if (cnt != 16'h0) begin
            cnt <= cnt - 16'h1;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  chk_cas_needs_ras: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(pins_o.cas_n) |-> !pins_o.ras_n)
    else $error("CAS fell without RAS"); // R11
  chk_read_we_high: assert property (@(posedge clk_i) disable iff (srst_i)
    (!pins_o.cas_n && !cur.write) |-> pins_o.write_n)
    else $error("WRITE low during read CAS"); // R6
  chk_rf_cas_high: assert property (@(posedge clk_i) disable iff (srst_i)
    (state == ST_RF) |-> (pins_o.cas_n && pins_o.cs_n))
    else $error("CAS or CS low in refresh"); // R19
  chk_warm_first: assert property (@(posedge clk_i) disable iff (srst_i)
    req_ready_o |-> warm_done_o)
    else $error("Request before warm-up"); // R20
  chk_ras_precharge: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(pins_o.ras_n) |=> pins_o.ras_n [*8] ##1 pins_o.ras_n [*3])
    else $error("RAS precharge too short"); // R1
  chk_page_ras_low: assert property (@(posedge clk_i) disable iff (srst_i)
    (state == ST_CP) |-> !pins_o.ras_n)
    else $error("RAS rose inside page"); // R17
  chk_rf_served: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(rf_due) |-> ##[1:200] (state == ST_RF))
    else $error("Refresh not served"); // R13
  chk_row_steps: assert property (@(posedge clk_i) disable iff (srst_i)
    (state == ST_RF && cnt == 16'h0) |=> rf_row == $past(rf_row) + 6'h1)
    else $error("Refresh row not advanced"); // R14
endmodule // dramc_host

// file: dramc_dev_model.sv
// Behavioural model of the 4096 x 1 DRAM seen from its pins
`timescale 1ns/100ps
module dramc_dev_model (
  input  wire logic       ras_n_i,
  input  wire logic       cas_n_i,
  input  wire logic       write_n_i,
  input  wire logic       cs_n_i,
  input  wire logic [5:0] addr_i,
  input  wire logic       din_i,
  output logic            dout_o,
  output logic            oe_o
);
  // ==========================================================
  // Array and latches
  logic       mem [4096];
  logic [5:0] row;
  logic [5:0] col;
  logic       sel;
  initial begin
    oe_o = 1'b0;
    dout_o = 1'b0;
    sel = 1'b0;
    // Contents after power-up are the parity of the address, never all zero
    for (int i = 0; i < 4096; i++) mem[i] = ^i[11:0];
  end
  always @(negedge ras_n_i) row = addr_i;
  // ==========================================================
  // Column cycle: float first, then latch, write and drive
  always @(negedge cas_n_i) begin
    oe_o = 1'b0;
    col = addr_i;
    sel = !cs_n_i && !ras_n_i;
    if (sel && !write_n_i) mem[{row, col}] = din_i;
    if (sel) begin
      dout_o <= #100 mem[{row, col}];
      oe_o <= #100 1'b1;
    end
  end
  always @(negedge write_n_i)
    if (sel && !cas_n_i && !ras_n_i) mem[{row, col}] = din_i;
endmodule // dramc_dev_model

// file: dramc_host_tb.sv
// Self-checking testbench of the DRAM host controller
`timescale 1ns/100ps
module dramc_host_tb;
  import dramc_pkg::*;
  localparam int RFSH = 200;
  logic        clk_i, srst_i, req_valid_i, req_ready_o;
  logic        rd_valid_o, rd_data_o, warm_done_o;
  logic        dout_i, m_dout, m_oe, flip;
  dramc_req_s  req_i, cur;
  dramc_pins_s pins_o;
  logic        ref_mem [4096];
  logic        known [4096];
  int          err_total, check_count, ras_cnt, rdv_cnt;

  dramc_host #(.RFSH_INTERVAL(RFSH)) DUT (.clk_i(clk_i), .srst_i(srst_i),
    .req_i(req_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .warm_done_o(warm_done_o), .pins_o(pins_o), .dout_i(dout_i));
  dramc_dev_model model (.ras_n_i(pins_o.ras_n), .cas_n_i(pins_o.cas_n),
    .write_n_i(pins_o.write_n), .cs_n_i(pins_o.cs_n), .addr_i(pins_o.addr),
    .din_i(pins_o.din), .dout_o(m_dout), .oe_o(m_oe));
  // Floating line toggles so a stale bit can never pass
  assign dout_i = m_oe ? m_dout : flip;

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ==========================================================
  // Checking and closing
  task automatic check(input string what, input logic [5:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wait_cas(input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (pins_o.cas_n !== lvl && n < 300);
    if (n >= 300) begin
      err_total++;
      wrap_up();
    end
  endtask
  // ==========================================================
  // Pin monitor
  always @(posedge clk_i) begin
    flip <= srst_i ? 1'b0 : ~flip;
    if (rd_valid_o === 1'b1) rdv_cnt++;
  end
  always @(negedge pins_o.ras_n) ras_cnt++;
  always @(negedge pins_o.cas_n) begin
    check("warm", {warm_done_o, ras_cnt >= 8}, 6'h3);
    check("write_n", pins_o.write_n, !cur.write);
    check("cs_n", pins_o.cs_n, !cur.select);
    check("col", pins_o.addr, cur.col);
    check("row", model.row, cur.row);
    if (cur.write) check("din", pins_o.din, cur.data);
  end
  // ==========================================================
  // Only a selected read brings a result back
  function automatic logic [5:0] exp_reads(input dramc_req_s r);
    return 6'(r.select && !r.write);
  endfunction
  // ==========================================================
  // One request, followed through its column cycle
  task automatic op(input dramc_req_s r);
    int          n;
    int          rdv0;
    logic [11:0] a;
    a = {r.row, r.col};
    n = 0;
    cur = r;
    req_i <= r;
    req_valid_i <= 1'b1;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (req_ready_o !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      err_total++;
      wrap_up();
    end
    rdv0 = rdv_cnt;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    wait_cas(1'b0);
    wait_cas(1'b1);
    repeat (3) @(posedge clk_i);
    check("rd_valid", 6'(rdv_cnt - rdv0), exp_reads(r));
    if (r.select && !r.write && known[a])
      check("rd_data", rd_data_o, ref_mem[a]);
    if (r.select && r.write) begin
      ref_mem[a] = r.data;
      known[a] = 1'b1;
    end
  endtask

  initial begin
    dramc_req_s r;
    int         r0;
    void'($urandom(32'h23D971A2));
    srst_i <= 1'b1;
    req_valid_i <= 1'b0;
    req_i <= '0;
    cur = '0;
    for (int i = 0; i < 4096; i++) known[i] = 1'b0;
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    // Page run, four writes first, then an unselected read, then read-back of the same row
    for (int k = 0; k < 9; k++) begin
      r = '{write: k < 4, page: 1'b1, select: k != 4, row: 6'h05,
            col: 6'(k % 4), data: k[0]};
      op(r);
    end
    for (int k = 0; k < 300; k++) begin
      r = dramc_req_s'(16'($urandom));
      r.row = 6'($urandom_range(3));
      r.col[5:3] = 3'h0;
      op(r);
    end
    // Idle stretch: refresh must keep coming without requests
    r0 = ras_cnt;
    repeat (1000) @(posedge clk_i);
    check("refresh", 6'(ras_cnt - r0 >= 1000 / RFSH - 1), 6'h01);
    wrap_up();
  end
endmodule // dramc_host_tb
